// ### src/timer_frontend.sv
/*
  Common front end of four timers (0 standard, 1..3 periodic): capture routing,
  clock selection, capture edges, match events, output pins, byte-buffered pairs.
  Assumes synchronous pins, one-cycle tick pulses, never read and write together.
*/
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module timer_frontend (
  input wire logic mclk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [timer_frontend_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [timer_frontend_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [timer_frontend_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
  input wire logic high_clk_tick, // Internal high clock enable pulse
  input wire logic sub_clk_tick, // Sub clock enable pulse
  input wire logic port_a4, // Standard capture pin, choice 0
  input wire logic port_b4, // Standard capture pin, choice 1
  input wire logic port_a5, // Periodic 0 capture pin, choice 0
  input wire logic port_d5, // Periodic 0 capture pin, choice 1
  input wire logic port_d7, // Periodic 1 capture pin, choice 0
  input wire logic port_d1, // Periodic 1 capture pin, choice 1
  input wire logic port_d6, // Periodic 2 capture pin, choice 0
  input wire logic port_d0, // Periodic 2 capture pin, choice 1
  input wire logic standard_ext_clock_in, // Standard timer external clock
  input wire logic [2:0] periodic_ext_clock_pin, // Periodic timers external clocks
  output logic [timer_frontend_pkg::NUM_TIMERS-1:0] timer_output_pin, // Output pins
  output logic [timer_frontend_pkg::NUM_TIMERS-1:0] match_a_irq, // Match A or capture event pulse
  output logic [timer_frontend_pkg::NUM_TIMERS-1:0] match_p_irq // Match P event pulse
);
  import timer_frontend_pkg::*;

  function automatic logic pick_tick(input logic [2:0] sel, input logic s4, input logic h16,
                                     input logic h64, input logic sb, input logic er,
                                     input logic ef);
    logic t;
    t = 1'b0;
    case (sel)
      CK_SYS_DIV4: t = s4;
      CK_SYS: t = 1'b1;
      CK_HIGH_DIV16: t = h16;
      CK_HIGH_DIV64: t = h64;
      CK_SUB_A, CK_SUB_B: t = sb;
      CK_EXT_RISE: t = er;
      default: t = ef;
    endcase
    return t;
  endfunction

  logic [3:0] insel_q;
  logic [1:0] sys_div_q;
  logic [5:0] high_div_q;
  logic [DATA_W-1:0] rdata_d;
  logic [7:0] ctrl0_q [NUM_TIMERS];
  logic [7:0] ctrl1_q [NUM_TIMERS];
  logic [CNT_W-1:0] cnt_q [NUM_TIMERS];
  logic [CNT_W-1:0] cmpa_q [NUM_TIMERS];
  logic [CNT_W-1:0] cmpp_q [NUM_TIMERS];
  logic [7:0] bufd_q [NUM_TIMERS];
  logic [7:0] bufa_q [NUM_TIMERS];
  logic [7:0] bufp_q [NUM_TIMERS];
  logic out_q [NUM_TIMERS];
  logic match_a_w [NUM_TIMERS];
  logic cap_w [NUM_TIMERS];
  logic on_rise_w [NUM_TIMERS];
  wire logic [NUM_TIMERS-1:0] cap_src;
  wire logic [NUM_TIMERS-1:0] ext_pin;
  wire logic sys4_tick;
  wire logic h16_tick;
  wire logic h64_tick;
  assign cap_src[0] = insel_q[0] ? port_b4 : port_a4;
  assign cap_src[1] = insel_q[1] ? port_d5 : port_a5;
  assign cap_src[2] = insel_q[2] ? port_d1 : port_d7;
  assign cap_src[3] = insel_q[3] ? port_d0 : port_d6;
  assign ext_pin = {periodic_ext_clock_pin, standard_ext_clock_in};

  // Prescalers: system clock / 4, high clock / 16 and / 64
  assign sys4_tick = (sys_div_q == 2'(SYS_DIV - 1));
  assign h16_tick = high_clk_tick && (high_div_q[3:0] == 4'(HIGH_DIV_A - 1));
  assign h64_tick = high_clk_tick && (high_div_q == 6'(HIGH_DIV_B - 1));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sys_div_q <= 2'h0;
      high_div_q <= 6'h00;
    end else begin
      sys_div_q <= sys_div_q + 2'h1;
      if (high_clk_tick) begin
        high_div_q <= high_div_q + 6'h01;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      insel_q <= INPUT_SEL_RST;
    end else if (wr && addr == INPUT_SEL_OFF) begin
      insel_q <= wdata[3:0];
    end
  end

  // Read decode; the low half of each pair is read from its byte buffer, the high half directly
  always_comb begin
    rdata_d = 8'h00;
    if (addr == INPUT_SEL_OFF) begin
      rdata_d = {4'h0, insel_q} & INPUT_SEL_MASK;
    end else if (addr[7:6] == 2'b00 && addr[3] == 1'b0) begin
      if (addr[2:0] == CTRL0_OFF[2:0]) begin
        rdata_d = ctrl0_q[addr[5:4]] & CTRL0_MASK;
      end else if (addr[2:0] == CTRL1_OFF[2:0]) begin
        rdata_d = ctrl1_q[addr[5:4]];
      end else if (addr[2:0] == CNT_LO_OFF[2:0]) begin
        rdata_d = bufd_q[addr[5:4]];
      end else if (addr[2:0] == CNT_HI_OFF[2:0]) begin
        rdata_d = cnt_q[addr[5:4]][15:8];
      end else if (addr[2:0] == CMPA_LO_OFF[2:0]) begin
        rdata_d = bufa_q[addr[5:4]];
      end else if (addr[2:0] == CMPA_HI_OFF[2:0]) begin
        rdata_d = cmpa_q[addr[5:4]][15:8];
      end else if (addr[2:0] == CMPP_LO_OFF[2:0]) begin
        rdata_d = bufp_q[addr[5:4]];
      end else begin
        rdata_d = cmpp_q[addr[5:4]][15:8];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

  // One slice per timer; all four share the same behaviour except that timer 0 cannot capture from its clock pin
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    logic ext_prev_q;
    logic cap_prev_q;
    logic on_prev_q;
    logic pulse_q;
    wire logic [7:0] base = 8'(i * TIMER_STRIDE);
    wire logic sel = (addr[7:4] == base[7:4]);
    wire logic wr_hit = wr && sel;
    wire logic rd_hit = rd && sel;
    wire logic [1:0] mode = ctrl1_q[i][MODE_LSB +: 2];
    wire logic [1:0] pin_fn = ctrl1_q[i][PINFN_LSB +: 2];
    wire logic init_lvl = ctrl1_q[i][INIT_BIT];
    wire logic run = ctrl0_q[i][ON_BIT] && !ctrl0_q[i][PAUSE_BIT];
    wire logic ext_rise = ext_pin[i] && !ext_prev_q;
    wire logic ext_fall = !ext_pin[i] && ext_prev_q;
    wire logic tick = run && pick_tick(ctrl0_q[i][CLKSEL_LSB +: 3], sys4_tick, h16_tick,
                                       h64_tick, sub_clk_tick, ext_rise, ext_fall);
    wire logic hit_a = tick && (cnt_q[i] == cmpa_q[i]);
    wire logic hit_p = tick && (cnt_q[i] == cmpp_q[i]);
    wire logic clr = ctrl1_q[i][CLR_ON_A_BIT] ? hit_a : hit_p;
    wire logic trig_sel = (i > 0) && ctrl1_q[i][CAP_FROM_CLK_BIT];
    wire logic cap_now = trig_sel ? ext_pin[i] : cap_src[i];
    wire logic cap_rise = cap_now && !cap_prev_q;
    wire logic cap_fall = !cap_now && cap_prev_q;
    wire logic cap_edge = (pin_fn == FN_00) ? cap_rise :
                          (pin_fn == FN_01) ? cap_fall :
                          (pin_fn == FN_10) ? (cap_rise || cap_fall) : 1'b0;
    wire logic capture = run && (mode == MODE_CAPTURE) && cap_edge;
    assign match_a_w[i] = hit_a;
    assign cap_w[i] = capture;
    assign on_rise_w[i] = ctrl0_q[i][ON_BIT] && !on_prev_q;
    assign timer_output_pin[i] = out_q[i];
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ctrl0_q[i] <= CTRL0_RST;
        ctrl1_q[i] <= CTRL1_RST;
        cmpa_q[i] <= CNT_RST;
        cmpp_q[i] <= CNT_RST;
        bufd_q[i] <= 8'h00;
        bufa_q[i] <= 8'h00;
        bufp_q[i] <= 8'h00;
      end else begin
        if (wr_hit && addr[3:0] == CTRL0_OFF) begin
          ctrl0_q[i] <= wdata & CTRL0_MASK;
        end
        if (wr_hit && addr[3:0] == CTRL1_OFF) begin
          ctrl1_q[i] <= wdata;
        end
        if (wr_hit && addr[3:0] == CMPA_LO_OFF) begin
          bufa_q[i] <= wdata;
        end else if (rd_hit && addr[3:0] == CMPA_HI_OFF) begin
          bufa_q[i] <= cmpa_q[i][7:0];
        end
        if (capture) begin
          cmpa_q[i] <= cnt_q[i];
        end else if (wr_hit && addr[3:0] == CMPA_HI_OFF) begin
          cmpa_q[i] <= {wdata, bufa_q[i]};
        end
        if (wr_hit && addr[3:0] == CMPP_LO_OFF) begin
          bufp_q[i] <= wdata;
        end else if (rd_hit && addr[3:0] == CMPP_HI_OFF) begin
          bufp_q[i] <= cmpp_q[i][7:0];
        end
        if (wr_hit && addr[3:0] == CMPP_HI_OFF) begin
          cmpp_q[i] <= {wdata, bufp_q[i]};
        end
        if (rd_hit && addr[3:0] == CNT_HI_OFF) begin
          bufd_q[i] <= cnt_q[i][7:0];
        end
      end
    end
    // Counter, edge history and output pin
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        cnt_q[i] <= CNT_RST;
        ext_prev_q <= 1'b0;
        cap_prev_q <= 1'b0;
        on_prev_q <= 1'b0;
        pulse_q <= 1'b0;
        out_q[i] <= 1'b0;
        match_a_irq[i] <= 1'b0;
        match_p_irq[i] <= 1'b0;
      end else begin
        ext_prev_q <= ext_pin[i];
        cap_prev_q <= cap_now;
        on_prev_q <= ctrl0_q[i][ON_BIT];
        match_a_irq[i] <= hit_a || capture;
        match_p_irq[i] <= hit_p;
        if (on_rise_w[i]) begin
          cnt_q[i] <= CNT_RST;
        end else if (tick) begin
          cnt_q[i] <= clr ? CNT_RST : cnt_q[i] + 16'h0001;
        end
        if (on_rise_w[i]) begin
          out_q[i] <= init_lvl;
          pulse_q <= 1'b0;
        end else if (mode == MODE_COMPARE && hit_a) begin
          case (pin_fn)
            FN_01: out_q[i] <= 1'b0;
            FN_10: out_q[i] <= 1'b1;
            FN_11: out_q[i] <= !out_q[i];
            default: out_q[i] <= out_q[i];
          endcase
        end else if (mode == MODE_PWM) begin
          case (pin_fn)
            FN_00: out_q[i] <= init_lvl;
            FN_01: out_q[i] <= !init_lvl;
            FN_10: out_q[i] <= (cnt_q[i] < cmpa_q[i]) ? !init_lvl : init_lvl;
            default: begin
              if (ctrl0_q[i][ON_BIT] && ext_rise && !pulse_q) begin
                pulse_q <= 1'b1;
                out_q[i] <= !init_lvl;
              end else if (pulse_q && hit_a) begin
                pulse_q <= 1'b0;
                out_q[i] <= init_lvl;
              end
            end
          endcase
        end
      end
    end
  end

  property p_insel_upper_zero;
    @(posedge mclk) disable iff (rst)
    (rd && addr == INPUT_SEL_OFF) |=> (rdata[7:4] == 4'h0 && rdata[3:0] == insel_q);
  endproperty
  a_insel_upper_zero: assert property (p_insel_upper_zero) else $error("select upper bits not zero");
  property p_std_route;
    @(posedge mclk) disable iff (rst)
    $changed(port_b4) && insel_q[0] |-> cap_src[0] == port_b4;
  endproperty
  a_std_route: assert property (p_std_route) else $error("standard capture route wrong");
  property p_p0_route;
    @(posedge mclk) disable iff (rst)
    !insel_q[1] |-> cap_src[1] == port_a5;
  endproperty
  a_p0_route: assert property (p_p0_route) else $error("periodic capture route wrong");
  property p_low_write_buffered;
    @(posedge mclk) disable iff (rst)
    (wr && addr == {4'h0, CMPA_LO_OFF} && !cap_w[0]) |=> cmpa_q[0] == $past(cmpa_q[0]);
  endproperty
  a_low_write_buffered: assert property (p_low_write_buffered) else $error("low write hit compare");
  property p_high_write_pair;
    @(posedge mclk) disable iff (rst)
    (wr && addr == {4'h0, CMPA_LO_OFF}) ##1 (wr && addr == {4'h0, CMPA_HI_OFF} && !cap_w[0])
      |=> cmpa_q[0] == {$past(wdata), $past(wdata, 2)};
  endproperty
  a_high_write_pair: assert property (p_high_write_pair) else $error("pair write wrong");
  property p_high_read_latch;
    @(posedge mclk) disable iff (rst)
    (rd && addr == {4'h0, CNT_HI_OFF}) ##1 (rd && addr == {4'h0, CNT_LO_OFF})
      |=> rdata == $past(cnt_q[0][7:0], 2);
  endproperty
  a_high_read_latch: assert property (p_high_read_latch) else $error("low read not buffered");
  property p_match_event;
    @(posedge mclk) disable iff (rst)
    match_a_w[2] |=> match_a_irq[2] ##1 (!match_a_irq[2] || $past(match_a_w[2] || cap_w[2]));
  endproperty
  a_match_event: assert property (p_match_event) else $error("match A event lost");
  property p_toggle;
    @(posedge mclk) disable iff (rst)
    (ctrl1_q[2][7:4] == 4'b0011 && match_a_w[2] && !on_rise_w[2])
      |=> timer_output_pin[2] != $past(timer_output_pin[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on match failed");
  property p_sys_div4;
    @(posedge mclk) disable iff (rst)
    sys4_tick |=> !sys4_tick [*3] ##1 sys4_tick;
  endproperty
  a_sys_div4: assert property (p_sys_div4) else $error("system divide by 4 wrong");
  property p_capture_off;
    @(posedge mclk) disable iff (rst)
    (ctrl1_q[1][7:4] == 4'b0111) |-> !cap_w[1] ##1 !match_a_irq[1] || $past(match_a_w[1]);
  endproperty
  a_capture_off: assert property (p_capture_off) else $error("capture while disabled");
endmodule
`default_nettype wire

// ### src/timer_frontend_pkg.sv
/*
  Constants shared by the timer front end: register map, field positions,
  reset values, clock-select and pin-function encodings, prescaler counts.
  Assumes an 8-bit register port with one byte per address.
*/
package timer_frontend_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_TIMERS = 4;
  localparam int CNT_W = 16;

  // Per-timer register block: timer n sits at n * TIMER_STRIDE
  localparam logic [7:0] TIMER_STRIDE = 8'h10;
  localparam logic [3:0] CTRL0_OFF = 4'h0;
  localparam logic [3:0] CTRL1_OFF = 4'h1;
  localparam logic [3:0] CNT_LO_OFF = 4'h2;
  localparam logic [3:0] CNT_HI_OFF = 4'h3;
  localparam logic [3:0] CMPA_LO_OFF = 4'h4;
  localparam logic [3:0] CMPA_HI_OFF = 4'h5;
  localparam logic [3:0] CMPP_LO_OFF = 4'h6;
  localparam logic [3:0] CMPP_HI_OFF = 4'h7;
  localparam logic [7:0] INPUT_SEL_OFF = 8'h40;

  // Control register 0 fields
  localparam int PAUSE_BIT = 7;
  localparam int CLKSEL_LSB = 4;
  localparam int ON_BIT = 3;
  localparam logic [7:0] CTRL0_MASK = 8'hf8;
  // Control register 1 fields
  localparam int MODE_LSB = 6;
  localparam int PINFN_LSB = 4;
  localparam int INIT_BIT = 3;
  localparam int CAP_FROM_CLK_BIT = 2;
  localparam int CLR_ON_A_BIT = 0;
  // Input select register
  localparam logic [7:0] INPUT_SEL_MASK = 8'h0f;

  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [3:0] INPUT_SEL_RST = 4'h0;
  localparam logic [15:0] CNT_RST = 16'h0000;

  localparam int SYS_DIV = 4;
  localparam int HIGH_DIV_A = 16;
  localparam int HIGH_DIV_B = 64;

  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'b000,
    CK_SYS = 3'b001,
    CK_HIGH_DIV16 = 3'b010,
    CK_HIGH_DIV64 = 3'b011,
    CK_SUB_A = 3'b100,
    CK_SUB_B = 3'b101,
    CK_EXT_RISE = 3'b110,
    CK_EXT_FALL = 3'b111
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } timer_mode_t;

  typedef enum logic [1:0] {
    FN_00 = 2'b00,
    FN_01 = 2'b01,
    FN_10 = 2'b10,
    FN_11 = 2'b11
  } pin_fn_t;
endpackage

// ### verif/test_timer_frontend.sv
/*
  Self-checking bench for the timer front end: register access, capture
  routing and edges, counter clock sources, compare and output pin actions.
  Assumes the register map and field layout of timer_frontend_pkg.
*/
`timescale 1ns/10ps
`default_nettype none
module test_timer_frontend;
  import timer_frontend_pkg::*;
  logic mclk, rst, wr, rd, high_tick, sub_tick, std_ck;
  logic [7:0] addr, wdata, rdata, v8;
  logic [3:0] pin_c0, pin_c1, out_pin, irq_a, irq_p;
  logic [2:0] per_ck;
  logic [15:0] v16;
  logic sa, sp, s1, s0;
  int errors, total_checks, cycles, fn;

  timer_frontend i_dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .high_clk_tick(high_tick), .sub_clk_tick(sub_tick),
    .port_a4(pin_c0[0]), .port_b4(pin_c1[0]), .port_a5(pin_c0[1]), .port_d5(pin_c1[1]),
    .port_d7(pin_c0[2]), .port_d1(pin_c1[2]), .port_d6(pin_c0[3]), .port_d0(pin_c1[3]),
    .standard_ext_clock_in(std_ck), .periodic_ext_clock_pin(per_ck),
    .timer_output_pin(out_pin), .match_a_irq(irq_a), .match_p_irq(irq_p)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the length of the whole sequence
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      close_out();
    end
  end

  function automatic logic [7:0] ra(input int t, input logic [3:0] off);
    ra = 8'(t) * TIMER_STRIDE + {4'h0, off};
  endfunction

  task check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // High byte first, then the buffered low byte, back to back
  task rd16(input int t, input logic [3:0] lo, output logic [15:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= ra(t, lo + 4'h1);
    @(posedge mclk);
    addr <= ra(t, lo);
    #1 v[15:8] = rdata;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v[7:0] = rdata;
  endtask

  // Low byte first, then the high byte, back to back
  task wr16(input int t, input logic [3:0] lo, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= ra(t, lo);
    wdata <= v[7:0];
    @(posedge mclk);
    addr <= ra(t, lo + 4'h1);
    wdata <= v[15:8];
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task watch(input int t, input int n);
    sa = 1'b0;
    sp = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      #1;
      sa = sa | irq_a[t];
      sp = sp | irq_p[t];
    end
  endtask

  task set_src(input int t, input int src, input logic v);
    case (src)
      0: pin_c0[t] <= v;
      1: pin_c1[t] <= v;
      default: if (t == 0) std_ck <= v; else per_ck[t-1] <= v;
    endcase
  endtask

  // One high-then-low pulse on a source, with the capture events expected
  task pulse(input int t, input int src, input logic er, input logic ef);
    @(posedge mclk);
    set_src(t, src, 1'b1);
    watch(t, 4);
    check("capture on rise", {7'h0, er}, {7'h0, sa});
    check("no match p", 8'h00, {7'h0, sp});
    @(posedge mclk);
    set_src(t, src, 1'b0);
    watch(t, 4);
    check("capture on fall", {7'h0, ef}, {7'h0, sa});
  endtask

  // Run timer 0 on one clock source for n units, then read the counter
  task count_case(input logic [2:0] sel, input int kind, input int n, input int exp, input int tol);
    wr_reg(ra(0, CTRL0_OFF), {1'b0, sel, 4'h8});
    repeat (n) begin
      @(posedge mclk);
      case (kind)
        1: high_tick <= 1'b1;
        2: sub_tick <= 1'b1;
        3: std_ck <= 1'b1;
        default: ;
      endcase
      if (kind != 0) begin
        @(posedge mclk);
        high_tick <= 1'b0;
        sub_tick <= 1'b0;
        if (kind == 3) begin
          @(posedge mclk);
          std_ck <= 1'b0;
          repeat (2) @(posedge mclk);
        end
      end
    end
    wr_reg(ra(0, CTRL0_OFF), {1'b0, sel, 4'h0});
    rd16(0, CNT_LO_OFF, v16);
    total_checks++;
    if ((v16 >= 16'(exp - tol) && v16 <= 16'(exp + tol)) !== 1'b1) begin
      errors++;
      $display("wrong value counter sel %b expected %0d seen %h", sel, exp, v16);
    end
  endtask

  // Timer 2 in compare mode, clear on A; A at 5, P at 3
  task cmp_case(input logic [1:0] f, input logic init, input logic exp);
    wr_reg(ra(2, CTRL0_OFF), 8'h00);
    wr_reg(ra(2, CTRL1_OFF), {2'b00, f, init, 3'b001});
    wr_reg(ra(2, CTRL0_OFF), 8'h18);
    s1 = 1'b0;
    s0 = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      #1;
      s0 = s0 | irq_p[2];
      if (irq_a[2] === 1'b1) begin
        s1 = 1'b1;
        break;
      end
    end
    check("match a event", 8'h01, {7'h0, s1});
    check("match p event", 8'h01, {7'h0, s0});
    check("output pin", {7'h0, exp}, {7'h0, out_pin[2]});
  endtask

  initial begin
    rst = 1'b1;
    {wr, rd, high_tick, sub_tick, std_ck} = 5'h00;
    addr = 8'h00;
    wdata = 8'h00;
    pin_c0 = 4'h0;
    pin_c1 = 4'h0;
    per_ck = 3'h0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(INPUT_SEL_OFF, v8);
    check("input select reset", 8'h00, v8);
    wr_reg(INPUT_SEL_OFF, 8'hff);
    rd_reg(INPUT_SEL_OFF, v8);
    check("input select upper bits", 8'h0f, v8);
    wr_reg(8'h80, 8'h5a);
    rd_reg(8'h80, v8);
    check("unmapped read", 8'h00, v8);
    // Compare P pair of timer 3: low write alone must not reach the register
    wr16(3, CMPP_LO_OFF, 16'h3412);
    rd16(3, CMPP_LO_OFF, v16);
    check("pair high", 8'h34, v16[15:8]);
    check("pair low", 8'h12, v16[7:0]);
    wr_reg(ra(3, CMPP_LO_OFF), 8'h56);
    rd16(3, CMPP_LO_OFF, v16);
    check("low after buffer write", 8'h12, v16[7:0]);
    wr_reg(ra(3, CMPP_LO_OFF), 8'h56);
    wr_reg(ra(3, CMPP_HI_OFF), 8'h78);
    rd16(3, CMPP_LO_OFF, v16);
    check("high after pair write", 8'h78, v16[15:8]);
    check("low copied on high write", 8'h56, v16[7:0]);
    // Capture routing and edge codes on every timer, counter on an idle sub clock
    for (int t = 0; t < NUM_TIMERS; t++) begin
      wr_reg(INPUT_SEL_OFF, 8'h00);
      wr_reg(ra(t, CTRL1_OFF), 8'h40);
      wr_reg(ra(t, CTRL0_OFF), 8'h48);
      pulse(t, 1, 1'b0, 1'b0);
      pulse(t, 0, 1'b1, 1'b0);
      wr_reg(INPUT_SEL_OFF, 8'(1 << t));
      pulse(t, 1, 1'b1, 1'b0);
      pulse(t, 0, 1'b0, 1'b0);
      for (fn = 1; fn < 4; fn++) begin
        wr_reg(ra(t, CTRL1_OFF), 8'h40 | 8'(fn << 4));
        pulse(t, 1, fn == 2, fn != 3);
      end
      wr_reg(ra(t, CTRL0_OFF), 8'h00);
    end
    wr_reg(ra(1, CTRL1_OFF), 8'h44);
    wr_reg(ra(1, CTRL0_OFF), 8'h48);
    pulse(1, 2, 1'b1, 1'b0);
    wr_reg(ra(1, CTRL0_OFF), 8'h00);
    // Every clock-select code; system clock counts get a small margin
    wr_reg(ra(0, CTRL1_OFF), 8'hc1);
    wr16(0, CMPA_LO_OFF, 16'h00ff);
    count_case(3'b000, 0, 40, 10, 2);
    count_case(3'b001, 0, 40, 40, 4);
    count_case(3'b010, 1, 32, 2, 1);
    count_case(3'b011, 1, 64, 1, 1);
    count_case(3'b100, 2, 5, 5, 0);
    count_case(3'b101, 2, 3, 3, 0);
    count_case(3'b110, 3, 4, 4, 0);
    count_case(3'b111, 3, 4, 4, 0);
    // Compare actions on match A
    wr16(2, CMPA_LO_OFF, 16'h0005);
    wr16(2, CMPP_LO_OFF, 16'h0003);
    cmp_case(2'b01, 1'b1, 1'b0);
    cmp_case(2'b10, 1'b0, 1'b1);
    cmp_case(2'b11, 1'b0, 1'b1);
    cmp_case(2'b00, 1'b1, 1'b1);
    // PWM on timer 3: duty from A, period from P
    wr16(3, CMPA_LO_OFF, 16'h0004);
    wr16(3, CMPP_LO_OFF, 16'h0008);
    wr_reg(ra(3, CTRL1_OFF), 8'ha0);
    wr_reg(ra(3, CTRL0_OFF), 8'h18);
    s1 = 1'b0;
    s0 = 1'b1;
    repeat (40) begin
      @(posedge mclk);
      #1;
      s1 = s1 | out_pin[3];
      s0 = s0 & out_pin[3];
    end
    check("pwm high seen", 8'h01, {7'h0, s1});
    check("pwm low seen", 8'h00, {7'h0, s0});
    // Single pulse on timer 1 started by its clock pin
    wr16(1, CMPA_LO_OFF, 16'h0100);
    wr_reg(ra(1, CTRL1_OFF), 8'hb1);
    wr_reg(ra(1, CTRL0_OFF), 8'h18);
    repeat (4) @(posedge mclk);
    #1 check("pulse before trigger", 8'h00, {7'h0, out_pin[1]});
    @(posedge mclk);
    per_ck[0] <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 check("pulse after trigger", 8'h01, {7'h0, out_pin[1]});
    close_out();
  end
endmodule
`default_nettype wire
